// ---- rtl/swm_master.v ----
// single-wire bus master: reset, byte slots, selection and search steps
`timescale 1ns/1ps
`include "swm_defs.vh"
module swm_master #(
  parameter RESET_LOW_CYC = `SWM_RESET_LOW_US * `SWM_CLK_MHZ,
  parameter RESET_HIGH_CYC = `SWM_RESET_HIGH_US * `SWM_CLK_MHZ,
  parameter FIFO_DEPTH = 32
) (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // command port
  input wire cmd_valid_i,
  input wire [2:0] cmd_op_i,
  input wire [7:0] cmd_data_i,
  output reg cmd_ready_o,
  // selection identity; search direction is taken from cmd_data_i bit 0
  input wire [63:0] sel_id_i,
  // read data out via fifo
  output reg rd_valid_o,
  input wire rd_ready_i,
  output reg [7:0] rd_data_o,
  // status
  output reg presence_o,
  output reg [1:0] search_bits_o,
  output reg done_o,
  // bus line
  input wire line_i,
  output reg line_o,
  output reg line_oe_o
);
  // cycle counts worked out as integers, then cut to the counter width on purpose
  localparam integer SLOT_N = `SWM_SLOT_US * `SWM_CLK_MHZ;
  localparam integer ONE_N = `SWM_WRITE_ONE_LOW_US * `SWM_CLK_MHZ;
  localparam integer ZERO_N = `SWM_WRITE_ZERO_LOW_US * `SWM_CLK_MHZ;
  localparam integer RSTART_N = `SWM_READ_START_LOW_US * `SWM_CLK_MHZ;
  localparam integer RSAMP_N = `SWM_READ_SAMPLE_US * `SWM_CLK_MHZ;
  localparam integer REC_N = `SWM_RECOVERY_US * `SWM_CLK_MHZ;
  localparam integer PRES_N = `SWM_PRESENCE_SAMPLE_US * `SWM_CLK_MHZ;
  localparam integer RLOW_N = RESET_LOW_CYC;
  localparam integer RHIGH_N = RESET_HIGH_CYC;
  // reset counts above 16 bits would wrap; keep overrides below 65536
  localparam [15:0] SLOT_CYC = SLOT_N[15:0];
  localparam [15:0] ONE_CYC = ONE_N[15:0];
  localparam [15:0] ZERO_CYC = ZERO_N[15:0];
  localparam [15:0] RSTART_CYC = RSTART_N[15:0];
  localparam [15:0] RSAMP_CYC = RSAMP_N[15:0];
  localparam [15:0] REC_CYC = REC_N[15:0];
  localparam [15:0] PRES_CYC = PRES_N[15:0];
  localparam [15:0] RLOW = RLOW_N[15:0];
  localparam [15:0] RHIGH = RHIGH_N[15:0];
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_RLOW = 4'h1;
  localparam [3:0] S_RHIGH = 4'h2;
  localparam [3:0] S_SLOT = 4'h3;
  localparam [3:0] S_REC = 4'h4;
  localparam [3:0] S_NEXT = 4'h5;
  localparam [3:0] S_PUSH = 4'h6;

  reg [3:0] st_r;
  reg [15:0] cnt_r;
  reg [2:0] op_r;
  reg [7:0] sh_r;
  reg [6:0] nbit_r;
  reg [63:0] id_r;
  reg bit_w_r;
  reg slot_rd_r;
  reg [1:0] step_r;
  reg samp_r;
  wire f_ready;
  wire f_valid;
  wire [7:0] f_data;
  reg f_push_r;

  // low time for the current slot
  function [15:0] low_time;
    input rd;
    input b;
    begin
      low_time = rd ? RSTART_CYC : (b ? ONE_CYC : ZERO_CYC);
    end
  endfunction

  // read bytes buffered toward the user
  swm_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(5)) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .in_valid_i(f_push_r),
    .in_ready_o(f_ready),
    .in_data_i(sh_r),
    .out_valid_o(f_valid),
    .out_ready_i(rd_ready_i && rd_valid_o),
    .out_data_o(f_data)
  );

  // output registers from fifo head
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o <= 8'h00;
    end else begin
      rd_valid_o <= f_valid && !(rd_ready_i && rd_valid_o);
      rd_data_o <= f_data;
    end
  end

  // main sequencer
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_r <= S_IDLE;
      cnt_r <= 16'h0000;
      op_r <= 3'h0;
      sh_r <= 8'h00;
      nbit_r <= 7'h00;
      id_r <= 64'h0;
      bit_w_r <= 1'b1;
      slot_rd_r <= 1'b0;
      step_r <= 2'h0;
      samp_r <= 1'b1;
      f_push_r <= 1'b0;
      cmd_ready_o <= 1'b0;
      presence_o <= 1'b0;
      search_bits_o <= 2'h0;
      done_o <= 1'b0;
      line_o <= 1'b0;
      line_oe_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      f_push_r <= 1'b0;
      line_o <= 1'b0;
      case (st_r)
        S_IDLE: begin
          line_oe_o <= 1'b0;
          cmd_ready_o <= 1'b1;
          if (cmd_valid_i && cmd_ready_o) begin
            cmd_ready_o <= 1'b0;
            op_r <= cmd_op_i;
            sh_r <= cmd_data_i;
            id_r <= sel_id_i;
            cnt_r <= 16'h0000;
            step_r <= 2'h0;
            case (cmd_op_i)
              `SWM_OP_RESET: begin
                st_r <= S_RLOW;
                line_oe_o <= 1'b1;
              end
              `SWM_OP_WRITE: nbit_r <= `SWM_BYTE_BITS;
              `SWM_OP_READ: nbit_r <= `SWM_BYTE_BITS;
              `SWM_OP_SEARCH: nbit_r <= `SWM_SEARCH_SLOTS;
              // selection sends its command byte, then the identity
              default: nbit_r <= `SWM_SEL_BITS;
            endcase
            if (cmd_op_i != `SWM_OP_RESET) begin
              st_r <= S_NEXT;
            end
          end
        end
        S_RLOW: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r == RLOW - 16'h0001) begin
            line_oe_o <= 1'b0;
            presence_o <= 1'b0;
            cnt_r <= 16'h0000;
            st_r <= S_RHIGH;
          end
        end
        S_RHIGH: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r == PRES_CYC && !line_i) begin
            presence_o <= 1'b1;
          end
          if (cnt_r == RHIGH - 16'h0001) begin
            done_o <= 1'b1;
            st_r <= S_IDLE;
          end
        end
        S_NEXT: begin
          // pick next bit; selection shifts command then id
          if (nbit_r == 7'h00) begin
            if (op_r == `SWM_OP_READ) begin
              st_r <= S_PUSH;
            end else begin
              done_o <= 1'b1;
              st_r <= S_IDLE;
            end
          end else begin
            // search: read, read complement, write chosen
            slot_rd_r <= (op_r == `SWM_OP_READ) ||
                         (op_r == `SWM_OP_SEARCH && step_r != 2'h2);
            if (op_r == `SWM_OP_SEARCH) begin
              bit_w_r <= sh_r[0];
            end else if (op_r == `SWM_OP_SEL && nbit_r <= `SWM_ID_BITS) begin
              bit_w_r <= id_r[0];
            end else begin
              bit_w_r <= (op_r == `SWM_OP_READ) ? 1'b1 : sh_r[0];
            end
            line_oe_o <= 1'b1;
            cnt_r <= 16'h0000;
            st_r <= S_SLOT;
          end
        end
        S_SLOT: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r == low_time(slot_rd_r, bit_w_r) - 16'h0001) begin
            line_oe_o <= 1'b0;
          end
          if (cnt_r == RSAMP_CYC) begin
            samp_r <= line_i;
          end
          if (cnt_r == SLOT_CYC - 16'h0001) begin
            cnt_r <= 16'h0000;
            st_r <= S_REC;
          end
        end
        S_REC: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r == REC_CYC - 16'h0001) begin
            nbit_r <= nbit_r - 7'h01;
            st_r <= S_NEXT;
            if (op_r == `SWM_OP_SEARCH) begin
              if (step_r == 2'h0) begin
                search_bits_o[0] <= samp_r;
              end
              if (step_r == 2'h1) begin
                search_bits_o[1] <= samp_r;
              end
              step_r <= step_r + 2'h1;
            end else if (op_r == `SWM_OP_SEL && nbit_r <= `SWM_ID_BITS) begin
              id_r <= {1'b0, id_r[63:1]};
            end else begin
              // reads collect the line; writes just echo their own bits
              sh_r <= {samp_r, sh_r[7:1]};
            end
          end
        end
        S_PUSH: begin
          // stall until fifo has room
          if (f_ready) begin
            f_push_r <= 1'b1;
            done_o <= 1'b1;
            st_r <= S_IDLE;
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end
endmodule

// ====================================================================
// synchronous fifo with valid and ready on both sides
module swm_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_r;
  reg [AW:0] rd_r;
  wire [AW:0] used = wr_r - rd_r;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = (used != DEPTH[AW:0]);
  assign out_valid_o = (used != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_r[AW-1:0]];
  // pointers and storage
  always @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data_i;
    end
    if (rst_i) begin
      wr_r <= {(AW+1){1'b0}};
      rd_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end
endmodule

// ---- rtl/swm_defs.vh ----
// timing and command constants for the single-wire bus master
// Contract
// - match command 55h then 64 identity bits selects one device.
// - search bit: read bit, read complement, then write chosen bit.
// - master repeats search step over all 64 bits per pass; here each search command runs one step (3 slots).
// - master drives reset low at least 480 us, then releases.
// - master initiates all signaling except the presence pulse.
// - every slot starts with the master pulling the line low.
// - read slot start low lasts at most 1 us.
// - read data valid 1 us to 15 us after the falling edge.
// - line stays released at least 480 us after reset pulse.
// - reset low time kept at most 960 us.
// - line idles high; never left low beyond 120 us except during the reset pulse.
// - order: reset and presence, selection command, function, data.
`ifndef SWM_DEFS_VH
`define SWM_DEFS_VH
`define SWM_CLK_MHZ 40
`define SWM_RESET_LOW_US 600
`define SWM_RESET_HIGH_US 600
`define SWM_PRESENCE_SAMPLE_US 70
`define SWM_SLOT_US 70
`define SWM_WRITE_ONE_LOW_US 6
`define SWM_WRITE_ZERO_LOW_US 64
`define SWM_READ_START_LOW_US 1
`define SWM_READ_SAMPLE_US 12
`define SWM_RECOVERY_US 2
`define SWM_CMD_READ_ID 8'h33
`define SWM_CMD_MATCH 8'h55
`define SWM_CMD_SKIP 8'hCC
`define SWM_CMD_SEARCH 8'hF0
`define SWM_OP_RESET 3'h0
`define SWM_OP_WRITE 3'h1
`define SWM_OP_READ 3'h2
`define SWM_OP_SEARCH 3'h3
`define SWM_OP_SEL 3'h4
`define SWM_BYTE_BITS 7'h08
`define SWM_SEARCH_SLOTS 7'h03
`define SWM_SEL_BITS 7'h48
`define SWM_ID_BITS 7'h40
`endif

// ---- rtl/swm_fifo.v ----
// the read-data fifo module is kept in swm_master.v beside the sequencer

// ---- verification/swm_master_assertions.sv ----
// assertion checker on the bus master ports
`timescale 1ns/1ps
`include "swm_defs.vh"
module swm_master_chk #(
  parameter RESET_LOW_CYC = 4000,
  parameter RESET_HIGH_CYC = 5600
) (
  // watched ports
  input wire sys_clk_i,
  input wire rst_i,
  input wire cmd_valid_i,
  input wire [2:0] cmd_op_i,
  input wire cmd_ready_o,
  input wire line_o,
  input wire line_oe_o
);
  // ====
  // run lengths of pulled line, released line and slot
  reg [19:0] lo_r, hi_r, sl_r;
  reg rst_r;
  always @(posedge sys_clk_i) begin
    lo_r <= line_oe_o ? lo_r + 20'h1 : 20'h0;
    hi_r <= rst_i ? 20'hFFFFF : line_oe_o ? 20'h0 : hi_r + {19'h0, ~&hi_r};
    sl_r <= rst_i ? 20'hFFFFF : line_oe_o && lo_r == 20'h0 ? 20'h1 : sl_r + {19'h0, ~&sl_r};
    if (rst_i) rst_r <= 1'b0;
    else if (!line_oe_o && lo_r != 20'h0) rst_r <= lo_r > 20'hA02;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  property p_pull_only; line_o == 1'b0; endproperty
  a_pull_only: assert property (p_pull_only) else $error("line driven high");
  property p_low_len; $fell(line_oe_o) |-> lo_r inside {[20'h26:20'h2A], [20'hEE:20'hF2],
    [20'h9FE:20'hA02], [RESET_LOW_CYC-2:RESET_LOW_CYC+2]}; endproperty
  a_low_len: assert property (p_low_len) else $error("bad low time");
  property p_low_max; line_oe_o |-> lo_r < RESET_LOW_CYC + 3; endproperty
  a_low_max: assert property (p_low_max) else $error("line held low too long");
  property p_recover; $rose(line_oe_o) |-> hi_r >= 20'h28; endproperty
  a_recover: assert property (p_recover) else $error("short recovery");
  property p_slot; $rose(line_oe_o) |-> sl_r >= 20'h960; endproperty
  a_slot: assert property (p_slot) else $error("short slot");
  property p_rst_high; $rose(line_oe_o) && rst_r |-> hi_r >= RESET_HIGH_CYC - 2; endproperty
  a_rst_high: assert property (p_rst_high) else $error("short reset high");
  property p_busy; cmd_valid_i && cmd_ready_o |=> !cmd_ready_o; endproperty
  a_busy: assert property (p_busy) else $error("ready while busy");
  property p_start; cmd_valid_i && cmd_ready_o |-> ##[1:3] line_oe_o; endproperty
  a_start: assert property (p_start) else $error("op did not pull low");
  c_reset: cover property (cmd_valid_i && cmd_ready_o && cmd_op_i == `SWM_OP_RESET);
  c_read: cover property (cmd_valid_i && cmd_ready_o && cmd_op_i == `SWM_OP_READ);
  c_search: cover property (cmd_valid_i && cmd_ready_o && cmd_op_i == `SWM_OP_SEARCH);
endmodule
bind swm_master swm_master_chk #(.RESET_LOW_CYC(RESET_LOW_CYC), .RESET_HIGH_CYC(RESET_HIGH_CYC))
  u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
  .cmd_ready_o(cmd_ready_o), .line_o(line_o), .line_oe_o(line_oe_o));

// ---- verification/swm_dev_model.sv ----
// behavioural memory token on the single-wire line
`timescale 1ns/1ps
module swm_dev_model #(
  parameter [7:0] RD_BYTE = 8'h3C,
  parameter [63:0] ID = 64'h5A00_0000_0000_0013 // arbitrary value
) (
  input wire clk_i,
  input wire line_i,
  output reg pull_o
);
  integer st, n, lo;
  reg [7:0] sh;
  reg w;
  // ====
  // one pass per falling edge of the line
  initial begin
    pull_o = 1'b0;
    st = 0;
    n = 0;
    forever begin
      @(negedge line_i);
      // zero held low, identity low bit first
      pull_o = st == 2 ? ~RD_BYTE[n] : st == 3 && n % 3 < 2 ? ~ID[n / 3] ^ (n % 3 == 1) : 1'b0;
      // timer from the edge, sample at 30 us
      for (lo = 0; lo < 1200; lo = lo + 1) begin
        @(posedge clk_i);
        if (lo == 600) pull_o = 1'b0;
      end
      w = line_i;
      while (line_i === 1'b0) begin
        @(posedge clk_i);
        lo = lo + 1;
      end
      if (lo > 3200) begin
        repeat (1200) @(posedge clk_i);
        pull_o = 1'b1;
        repeat (4000) @(posedge clk_i);
        pull_o = 1'b0;
        st = 1;
        n = 0;
      end else if (st == 1) begin
        sh = {w, sh[7:1]};
        n = n + 1;
        if (n == 8) st = sh == 8'hCC ? 2 : sh == 8'hF0 ? 3 : 0;
        if (n == 8) n = 0;
      end else if (st > 1) begin
        if (st == 3 && n % 3 == 2 && w !== ID[n / 3]) st = 0;
        n = st == 2 ? (n + 1) % 8 : n + 1;
      end
    end
  end
endmodule

// ---- verification/tb_swm_master.sv ----
// testbench for the bus master, device model and read fifo
`timescale 1ns/1ps
`include "swm_defs.vh"
module tb_swm_master;
  localparam [7:0] RB = 8'h3C;
  localparam [63:0] IDV = 64'h5A00_0000_0000_0013; // arbitrary value
  reg clk = 1'b0, rst = 1'b1, cv = 1'b0, rr = 1'b0;
  reg [2:0] op = 3'h0;
  reg [7:0] cd = 8'h00;
  wire ready, rv, pres, done, lo, oe, pull;
  wire [7:0] rd;
  wire [1:0] sb;
  // pulled-up open-drain line
  wire line = ~(oe | pull);
  integer fails = 0, cmp_count = 0, k;
  always #12.5 clk = ~clk;
  swm_master #(.RESET_LOW_CYC(4000), .RESET_HIGH_CYC(5600)) dut (.sys_clk_i(clk), .rst_i(rst),
    .cmd_valid_i(cv), .cmd_op_i(op), .cmd_data_i(cd), .cmd_ready_o(ready), .sel_id_i(64'h0),
    .rd_valid_o(rv), .rd_ready_i(rr), .rd_data_o(rd), .presence_o(pres), .search_bits_o(sb),
    .done_o(done), .line_i(line), .line_o(lo), .line_oe_o(oe));
  swm_dev_model #(.RD_BYTE(RB), .ID(IDV)) m (.clk_i(clk), .line_i(line), .pull_o(pull));
  task check(input [63:0] seen, input [63:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) fails = fails + 1;
      if (seen !== exp) $display("unexpected at %0t: %0h vs %0h", $time, seen, exp);
    end
  endtask
  task complete_run;
    begin
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // one command, held until taken, then bounded wait for done
  task run_op(input [2:0] o, input [7:0] d);
    begin
      @(negedge clk);
      op = o;
      cd = d;
      cv = 1'b1;
      for (k = 0; k < 50 && ready !== 1'b1; k = k + 1) @(negedge clk);
      @(negedge clk);
      cv = 1'b0;
      for (k = 0; k < 40000 && done !== 1'b1; k = k + 1) @(negedge clk);
      if (k == 40000) fails = fails + 1;
      if (k == 40000) complete_run;
    end
  endtask
  // reset between scenarios with the master idle: outputs clear, line let go, ready one edge after release
  task sc_rst;
    begin
      @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      check({pres, sb, done, rv}, 5'h00);
      check({oe, lo, ready}, 3'h0);
      rst = 1'b0;
      @(negedge clk);
      check(ready, 1'b1);
    end
  endtask
  // reset, search command, one step with the losing direction
  task sc_search;
    begin
      run_op(`SWM_OP_RESET, 8'h00);
      check(pres, 1'b1);
      run_op(`SWM_OP_WRITE, `SWM_CMD_SEARCH);
      check(m.st, 3);
      run_op(`SWM_OP_SEARCH, {7'h00, ~IDV[0]});
      check(sb, {~IDV[0], IDV[0]});
      check(m.st, 0);
      check({oe, lo}, 2'h0);
    end
  endtask
  // reset, skip command, read one byte through the fifo
  task sc_read;
    begin
      run_op(`SWM_OP_RESET, 8'h00);
      check(pres, 1'b1);
      run_op(`SWM_OP_WRITE, `SWM_CMD_SKIP);
      check(m.st, 2);
      check(rv, 1'b0);
      run_op(`SWM_OP_READ, 8'h00);
      // the fifo and its output register lag done by two edges
      for (k = 0; k < 8 && rv !== 1'b1; k = k + 1) @(negedge clk);
      if (k == 8) fails = fails + 1;
      if (k == 8) complete_run;
      rr = 1'b1;
      check({rv, rd}, {1'b1, RB});
      @(negedge clk);
      rr = 1'b0;
      check(rv, 1'b0);
    end
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    sc_search;
    sc_rst;
    sc_read;
    complete_run;
  end
endmodule
